// *** design/mie_defs.vh ***
/*
  shared constants of the instruction execution core: machine cycle
  length, strobe windows, internal ram limits, sfr addresses, psw
  fields and reset values. assumes it is included by bare name.
*/
`ifndef MIE_DEFS_VH
`define MIE_DEFS_VH
// clk cycles per machine cycle and per bus access
`define MC_CLKS 6'h0c
`define FETCH_CLKS 3'h2
`define XFER_CLKS 3'h4
// internal ram: last byte index and start of bit area
`define IRAM_TOP 8'hbf
`define BIT_RAM_BASE 8'h20
// sfr addresses
`define SFR_ACC 8'he0
`define SFR_B 8'hf0
`define SFR_PSW 8'hd0
`define SFR_SP 8'h81
`define SFR_DPL 8'h82
`define SFR_DPH 8'h83
// psw field positions
`define PSW_CY 7
`define PSW_AC 6
`define PSW_OV 2
`define PSW_RS_HI 4
`define PSW_RS_LO 3
// reset values
`define SP_RST 8'h07
`define PSW_RST 8'h00
`define PC_RST 16'h0000
`endif

// *** design/mie_core.v ***
/*
  mie_core: fetches and executes the arithmetic, logic and data
  transfer groups of an 8-bit core, with internal ram, a b register,
  stack pointer and 16-bit data pointer.
  assumes code memory and external data memory return data within the
  strobe windows, and all inputs are synchronous to clk.
*/
`timescale 1ns/100ps
`include "mie_defs.vh"

module mie_core (
  input wire clk,
  input wire sys_rst,
  output reg [15:0] codeAddr,
  input wire [7:0] codeData,
  output reg progStoreN,
  output reg [15:0] extAddr,
  output reg [7:0] extWriteData,
  input wire [7:0] extReadData,
  output reg dataReadN,
  output reg dataWriteN,
  output reg [7:0] acc,
  output reg [7:0] psw,
  output reg instrStart
);
  localparam [2:0] ST_START = 3'h0;
  localparam [2:0] ST_FETCH = 3'h1;
  localparam [2:0] ST_EXEC = 3'h2;
  localparam [2:0] ST_XRD = 3'h3;
  localparam [2:0] ST_XWR = 3'h4;
  localparam [2:0] ST_CRD = 3'h5;
  localparam [2:0] ST_WAIT = 3'h6;

  reg [2:0] state;
  reg [15:0] pc;
  reg [15:0] data_pointer_16;
  reg [7:0] b;
  reg [7:0] sp;
  reg [7:0] opcode;
  reg [7:0] op1;
  reg [7:0] op2;
  reg [1:0] byteIdx;
  reg [5:0] clkCnt;
  reg [2:0] accCnt;
  reg [7:0] iram [0:`IRAM_TOP];
  reg [7:0] next_acc;
  reg [7:0] next_b;
  reg [7:0] next_psw;
  reg [7:0] next_sp;
  reg [15:0] next_data_pointer_16;
  reg opndWe;
  reg [7:0] opndData;
  reg dirWe;
  reg [7:0] dirAddr;
  reg [7:0] dirData;
  reg memWe;
  reg [7:0] memAddr;
  reg [7:0] memData;

  // byte count of an instruction, from its opcode
  function [1:0] opLen;
    input [7:0] op;
    reg [3:0] h;
    begin
      h = op[7:4];
      case (op[3:0])
        4'h0: opLen = (h == 4'h9) ? 2'h3 :
          (h == 4'hc || h == 4'hd) ? 2'h2 : 2'h1;
        4'h1: opLen = 2'h1;
        4'h2: opLen = ((h >= 4'h4 && h <= 4'h6) ||
          (h >= 4'hb && h <= 4'hd)) ? 2'h2 : 2'h1;
        4'h3: opLen = (h >= 4'h4 && h <= 4'h6) ? 2'h3 : 2'h1;
        4'h4: opLen = ((h >= 4'h2 && h <= 4'h7) || h == 4'h9) ?
          2'h2 : 2'h1;
        4'h5: opLen = (h == 4'h7 || h == 4'h8) ? 2'h3 : 2'h2;
        default: opLen = (h == 4'h7 || h == 4'h8 || h == 4'ha) ?
          2'h2 : 2'h1;
      endcase
    end
  endfunction

  // machine cycles of an instruction, from its opcode
  function [2:0] opCyc;
    input [7:0] op;
    reg [3:0] h;
    begin
      h = op[7:4];
      case (op[3:0])
        4'h0: opCyc = (h == 4'h9 || h >= 4'hc) ? 3'h2 : 3'h1;
        4'h2: opCyc = (h >= 4'he) ? 3'h2 : 3'h1;
        4'h3: opCyc = ((h >= 4'h4 && h <= 4'h6) ||
          (h >= 4'h8 && h <= 4'ha) || h >= 4'he) ? 3'h2 : 3'h1;
        4'h4: opCyc = (h == 4'h8 || h == 4'ha) ? 3'h4 : 3'h1;
        4'h5: opCyc = (h == 4'h7 || h == 4'h8) ? 3'h2 : 3'h1;
        default: opCyc = ((h == 4'h8 || h == 4'ha) && op[3:0] != 4'h1) ?
          3'h2 : 3'h1;
      endcase
    end
  endfunction

  // byte holding a bit address: ram bit area or sfr row
  function [7:0] bitByte;
    input [7:0] ba;
    begin
      if (ba[7])
        bitByte = {ba[7:3], 3'h0};
      else
        bitByte = `BIT_RAM_BASE + {4'h0, ba[6:3]};
    end
  endfunction

  // direct space read: low half is ram, high half the sfrs; every source
  // is an argument so a continuous caller wakes up when any of them moves
  function [7:0] readDir;
    input [7:0] a;
    input [7:0] ramByte;
    input [7:0] accV;
    input [7:0] bV;
    input [7:0] pswV;
    input [7:0] spV;
    input [15:0] dpV;
    begin
      if (!a[7])
        readDir = ramByte;
      else begin
        case (a)
          `SFR_ACC: readDir = accV;
          `SFR_B: readDir = bV;
          `SFR_PSW: readDir = pswV;
          `SFR_SP: readDir = spV;
          `SFR_DPL: readDir = dpV[7:0];
          `SFR_DPH: readDir = dpV[15:8];
          default: readDir = 8'h00;
        endcase
      end
    end
  endfunction

  // or, and, xor chosen by the opcode row
  function [7:0] logicOp;
    input [3:0] h;
    input [7:0] x;
    input [7:0] y;
    begin
      case (h)
        4'h4: logicOp = x | y;
        4'h5: logicOp = x & y;
        default: logicOp = x ^ y;
      endcase
    end
  endfunction

  wire [3:0] lo = opcode[3:0];
  wire [3:0] hi = opcode[7:4];
  wire [7:0] rnIdx = {3'h0, psw[`PSW_RS_HI:`PSW_RS_LO], opcode[2:0]};
  wire [7:0] riPtr = iram[{3'h0, psw[`PSW_RS_HI:`PSW_RS_LO], 2'h0, opcode[0]}];
  // indirect reach stops at the top of ram; above it reads zero
  wire [7:0] indVal = (riPtr <= `IRAM_TOP) ? iram[riPtr] : 8'h00;
  wire [7:0] dirVal = readDir(op1, iram[op1], acc, b, psw, sp, data_pointer_16);
  wire [7:0] srcVal = (lo == 4'h4) ? op1 : (lo == 4'h5) ? dirVal :
    (lo[3:1] == 3'h3) ? indVal : iram[rnIdx];
  wire [7:0] tgtVal = (lo == 4'h4) ? acc : srcVal;
  wire [7:0] stackVal = (sp <= `IRAM_TOP) ? iram[sp] : 8'h00;
  wire [7:0] bitAddr = bitByte(op1);
  wire [7:0] bitVal = readDir(bitAddr, iram[bitAddr], acc, b, psw, sp,
    data_pointer_16);
  wire [7:0] bitMask = 8'h01 << op1[2:0];
  wire [1:0] fetchLen = opLen((byteIdx == 2'h0) ? codeData : opcode);
  wire [5:0] lastClk = {3'h0, opCyc(opcode)} * `MC_CLKS - 6'h01;

  // one adder serves add, add with carry and subtract with borrow
  wire isSub = (hi == 4'h9);
  wire [7:0] addOpnd = isSub ? ~srcVal : srcVal;
  wire addCin = isSub ? ~psw[`PSW_CY] :
    (hi == 4'h3) & psw[`PSW_CY];
  wire [4:0] halfSum = {1'h0, acc[3:0]} + {1'h0, addOpnd[3:0]} +
    {4'h0, addCin};
  wire [8:0] fullSum = {1'h0, acc} + {1'h0, addOpnd} + {8'h00, addCin};
  wire addOv = (acc[7] == addOpnd[7]) && (fullSum[7] != acc[7]);

  // multiply and divide; divide by zero leaves acc and b alone
  wire [15:0] product = acc * b;
  wire [7:0] quot = (b == 8'h00) ? acc : acc / b;
  wire [7:0] remain = (b == 8'h00) ? b : acc % b;

  // decimal adjust in two steps; carry is only ever set
  wire [8:0] daLow = (acc[3:0] > 4'h9 || psw[`PSW_AC]) ?
    {1'h0, acc} + 9'h006 : {1'h0, acc};
  wire daCy = daLow[8] | psw[`PSW_CY];
  wire [8:0] daFull = (daLow[7:4] > 4'h9 || daCy) ?
    {1'h0, daLow[7:0]} + 9'h060 : {1'h0, daLow[7:0]};

  // instruction effects, applied in the execute state
  always @* begin
    next_acc = acc;
    next_b = b;
    next_psw = psw;
    next_sp = sp;
    next_data_pointer_16 = data_pointer_16;
    opndWe = 1'h0;
    opndData = 8'h00;
    dirWe = 1'h0;
    dirAddr = op1;
    dirData = 8'h00;
    memWe = 1'h0;
    memAddr = 8'h00;
    memData = 8'h00;
    case (hi)
      4'h0, 4'h1: begin
        if (lo == 4'h3) begin
          next_acc = {hi[0] ? psw[`PSW_CY] : acc[0], acc[7:1]};
          if (hi[0])
            next_psw[`PSW_CY] = acc[0];
        end else if (lo >= 4'h4) begin
          opndData = hi[0] ? tgtVal - 8'h01 : tgtVal + 8'h01;
          opndWe = (lo != 4'h4);
          if (lo == 4'h4)
            next_acc = opndData;
        end
      end
      4'h2, 4'h3: begin
        if (lo == 4'h3) begin
          next_acc = {acc[6:0], hi[0] ? psw[`PSW_CY] : acc[7]};
          if (hi[0])
            next_psw[`PSW_CY] = acc[7];
        end
      end
      4'h4, 4'h5, 4'h6: begin
        if (lo == 4'h2 || lo == 4'h3) begin
          dirWe = 1'h1;
          dirData = logicOp(hi, dirVal, (lo == 4'h2) ? acc : op2);
        end else if (lo >= 4'h4)
          next_acc = logicOp(hi, acc, srcVal);
      end
      4'h7: begin
        if (lo == 4'h4)
          next_acc = op1;
        else if (lo >= 4'h5) begin
          opndWe = 1'h1;
          opndData = (lo == 4'h5) ? op2 : op1;
        end
      end
      4'h8: begin
        if (lo == 4'h4) begin
          next_acc = quot;
          next_b = remain;
          next_psw[`PSW_CY] = 1'h0;
          next_psw[`PSW_OV] = (b == 8'h00);
        end else if (lo >= 4'h5) begin
          dirWe = 1'h1;
          dirAddr = (lo == 4'h5) ? op2 : op1;
          dirData = srcVal;
        end
      end
      4'h9: begin
        if (lo == 4'h0)
          next_data_pointer_16 = {op1, op2};
      end
      4'ha: begin
        if (lo == 4'h3)
          next_data_pointer_16 = data_pointer_16 + 16'h0001;
        else if (lo == 4'h4) begin
          next_acc = product[7:0];
          next_b = product[15:8];
          next_psw[`PSW_CY] = 1'h0;
          next_psw[`PSW_OV] = (product[15:8] != 8'h00);
        end else if (lo >= 4'h6) begin
          opndWe = 1'h1;
          opndData = dirVal;
        end
      end
      4'hb, 4'hc, 4'hd: begin
        if (lo == 4'h2) begin
          dirWe = 1'h1;
          dirAddr = bitAddr;
          dirData = (hi == 4'hb) ? bitVal ^ bitMask :
            (hi == 4'hc) ? bitVal & ~bitMask : bitVal | bitMask;
        end else if (hi == 4'hc && lo == 4'h0) begin
          next_sp = sp + 8'h01;
          memWe = 1'h1;
          memAddr = sp + 8'h01;
          memData = dirVal;
        end else if (hi == 4'hd && lo == 4'h0) begin
          dirWe = 1'h1;
          dirData = stackVal;
          next_sp = sp - 8'h01;
        end else if (hi == 4'hc && lo == 4'h4)
          next_acc = {acc[3:0], acc[7:4]};
        else if (hi == 4'hc && lo >= 4'h5) begin
          next_acc = srcVal;
          opndWe = 1'h1;
          opndData = acc;
        end else if (hi == 4'hd && lo == 4'h4) begin
          next_acc = daFull[7:0];
          next_psw[`PSW_CY] = daCy | daFull[8];
        end else if (hi == 4'hd && lo[3:1] == 3'h3) begin
          next_acc = {acc[7:4], indVal[3:0]};
          opndWe = 1'h1;
          opndData = {indVal[7:4], acc[3:0]};
        end
      end
      4'he: begin
        if (lo == 4'h4)
          next_acc = 8'h00;
        else if (lo >= 4'h5)
          next_acc = srcVal;
      end
      default: begin
        if (lo == 4'h4)
          next_acc = ~acc;
        else if (lo >= 4'h5) begin
          opndWe = 1'h1;
          opndData = acc;
        end
      end
    endcase
    // arithmetic group shares flag handling
    if (lo >= 4'h4 && (hi == 4'h2 || hi == 4'h3 || isSub)) begin
      next_acc = fullSum[7:0];
      next_psw[`PSW_CY] = fullSum[8] ^ isSub;
      next_psw[`PSW_AC] = halfSum[4] ^ isSub;
      next_psw[`PSW_OV] = addOv;
    end
    // operand target: direct, indirect or working register
    if (opndWe) begin
      if (lo == 4'h5) begin
        dirWe = 1'h1;
        dirData = opndData;
      end else begin
        memWe = 1'h1;
        memAddr = lo[3] ? rnIdx : riPtr;
        memData = opndData;
      end
    end
    // a direct write lands last so it wins over implicit updates except parity, which the execute state recomputes
    if (dirWe) begin
      if (!dirAddr[7]) begin
        memWe = 1'h1;
        memAddr = dirAddr;
        memData = dirData;
      end else begin
        case (dirAddr)
          `SFR_ACC: next_acc = dirData;
          `SFR_B: next_b = dirData;
          `SFR_PSW: next_psw = dirData;
          `SFR_SP: next_sp = dirData;
          `SFR_DPL: next_data_pointer_16[7:0] = dirData;
          `SFR_DPH: next_data_pointer_16[15:8] = dirData;
          default: next_acc = acc;
        endcase
      end
    end
  end

  // sequencer: fetch, execute, bus access, then pad to full cycles
  always @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_START;
      pc <= `PC_RST;
      data_pointer_16 <= 16'h0000;
      acc <= 8'h00;
      b <= 8'h00;
      psw <= `PSW_RST;
      sp <= `SP_RST;
      opcode <= 8'h00;
      op1 <= 8'h00;
      op2 <= 8'h00;
      byteIdx <= 2'h0;
      clkCnt <= 6'h00;
      accCnt <= 3'h0;
      codeAddr <= `PC_RST;
      progStoreN <= 1'h1;
      extAddr <= 16'h0000;
      extWriteData <= 8'h00;
      dataReadN <= 1'h1;
      dataWriteN <= 1'h1;
      instrStart <= 1'h0;
    end else begin
      clkCnt <= clkCnt + 6'h01;
      instrStart <= 1'h0;
      case (state)
        ST_START: begin
          codeAddr <= pc;
          progStoreN <= 1'h0;
          byteIdx <= 2'h0;
          accCnt <= 3'h0;
          instrStart <= 1'h1;
          state <= ST_FETCH;
        end
        ST_FETCH: begin
          if (accCnt == `FETCH_CLKS - 3'h1) begin
            accCnt <= 3'h0;
            pc <= pc + 16'h0001;
            codeAddr <= pc + 16'h0001;
            if (byteIdx == 2'h0)
              opcode <= codeData;
            else if (byteIdx == 2'h1)
              op1 <= codeData;
            else
              op2 <= codeData;
            if (byteIdx + 2'h1 == fetchLen) begin
              progStoreN <= 1'h1;
              state <= ST_EXEC;
            end else
              byteIdx <= byteIdx + 2'h1;
          end else
            accCnt <= accCnt + 3'h1;
        end
        ST_EXEC: begin
          acc <= next_acc;
          b <= next_b;
          psw <= {next_psw[7:1], ^next_acc};
          sp <= next_sp;
          data_pointer_16 <= next_data_pointer_16;
          if (memWe && memAddr <= `IRAM_TOP)
            iram[memAddr] <= memData;
          accCnt <= 3'h0;
          if (opcode == 8'he0 || opcode[7:1] == 7'h71) begin
            extAddr <= opcode[1] ? {8'h00, riPtr} : data_pointer_16;
            dataReadN <= 1'h0;
            state <= ST_XRD;
          end else if (opcode == 8'hf0 || opcode[7:1] == 7'h79) begin
            extAddr <= opcode[1] ? {8'h00, riPtr} : data_pointer_16;
            extWriteData <= acc;
            dataWriteN <= 1'h0;
            state <= ST_XWR;
          end else if (opcode == 8'h83 || opcode == 8'h93) begin
            codeAddr <= {8'h00, acc} + (opcode[4] ? data_pointer_16 : pc);
            progStoreN <= 1'h0;
            state <= ST_CRD;
          end else
            state <= ST_WAIT;
        end
        ST_XRD: begin
          if (accCnt == `XFER_CLKS - 3'h1) begin
            acc <= extReadData;
            psw[0] <= ^extReadData;
            dataReadN <= 1'h1;
            state <= ST_WAIT;
          end else
            accCnt <= accCnt + 3'h1;
        end
        ST_XWR: begin
          if (accCnt == `XFER_CLKS - 3'h1) begin
            dataWriteN <= 1'h1;
            state <= ST_WAIT;
          end else
            accCnt <= accCnt + 3'h1;
        end
        ST_CRD: begin
          if (accCnt == `FETCH_CLKS - 3'h1) begin
            acc <= codeData;
            psw[0] <= ^codeData;
            progStoreN <= 1'h1;
            state <= ST_WAIT;
          end else
            accCnt <= accCnt + 3'h1;
        end
        ST_WAIT: begin
          // instruction length is exact, so timing loops stay true
          if (clkCnt >= lastClk) begin
            clkCnt <= 6'h00;
            state <= ST_START;
          end
        end
        default: state <= ST_START;
      endcase
    end
  end
endmodule // mie_core

// *** verif/mie_core_props.sv ***
/*
  mie_core_props: concurrent checks on the ports of mie_core, bound in
  at the foot of this file. assumes one clock and synchronous reset.
*/
`timescale 1ns/100ps
module mie_core_props (
  input wire clk,
  input wire sys_rst,
  input wire [15:0] codeAddr,
  input wire [7:0] codeData,
  input wire progStoreN,
  input wire [15:0] extAddr,
  input wire [7:0] extWriteData,
  input wire [7:0] extReadData,
  input wire dataReadN,
  input wire dataWriteN,
  input wire [7:0] acc,
  input wire [7:0] psw,
  input wire instrStart
);
  reg [7:0] gap;
  reg armed;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // clocks since the last start; saturates so a hang cannot wrap to a match
  always @(posedge clk) begin
    if (sys_rst) begin
      gap <= 8'h00;
      armed <= 1'b0;
    end else if (instrStart) begin
      gap <= 8'h01;
      armed <= 1'b1;
    end else if (gap != 8'hff) begin
      gap <= gap + 8'h01;
    end
  end

  rst_values_a:
    assert property ($fell(sys_rst) |-> progStoreN && dataReadN &&
      dataWriteN && !instrStart && acc == 8'h00 && psw == 8'h00)
    else $error("outputs not at reset values");
  start_gap_a:
    assert property (instrStart && armed |->
      gap == 8'h0c || gap == 8'h18 || gap == 8'h30)
    else $error("instruction length not whole machine cycles");
  fetch_hold_a:
    assert property (instrStart |-> !progStoreN ##1
      (!progStoreN && $stable(codeAddr) && !instrStart))
    else $error("opcode fetch window broken");
  read_len_a:
    assert property ($fell(dataReadN) |-> !dataReadN [*4] ##1 dataReadN)
    else $error("read strobe not four clocks");
  write_len_a:
    assert property ($fell(dataWriteN) |-> !dataWriteN [*4] ##1 dataWriteN)
    else $error("write strobe not four clocks");
  strobe_excl_a:
    assert property (!dataReadN || !dataWriteN |->
      progStoreN && (dataReadN || dataWriteN))
    else $error("strobes overlap");
  read_load_a:
    assert property ($rose(dataReadN) |-> acc == $past(extReadData))
    else $error("read data not loaded into accumulator");
  write_data_a:
    assert property ($fell(dataWriteN) |-> extWriteData == acc ##1
      ($stable(extAddr) && $stable(extWriteData)) [*3])
    else $error("write address or data moved");
  parity_a:
    assert property ($stable(acc) [*2] |-> psw[0] == ^acc)
    else $error("parity flag wrong");
endmodule // mie_core_props

bind mie_core mie_core_props chk (
  .clk(clk),
  .sys_rst(sys_rst),
  .codeAddr(codeAddr),
  .codeData(codeData),
  .progStoreN(progStoreN),
  .extAddr(extAddr),
  .extWriteData(extWriteData),
  .extReadData(extReadData),
  .dataReadN(dataReadN),
  .dataWriteN(dataWriteN),
  .acc(acc),
  .psw(psw),
  .instrStart(instrStart)
);

// *** verif/mie_mem_model.sv ***
/*
  mie_mem_model: code memory and external data memory beside the core.
  assumes 256-byte arrays; upper address bits alias.
*/
`timescale 1ns/100ps
module mie_mem_model (
  input wire clk,
  input wire [15:0] codeAddr,
  input wire progStoreN,
  output wire [7:0] codeData,
  input wire [15:0] extAddr,
  input wire [7:0] extWriteData,
  output wire [7:0] extReadData,
  input wire dataReadN,
  input wire dataWriteN
);
  logic [7:0] code [0:255];
  logic [7:0] xram [0:255];
  logic [15:0] lastWr;
  logic [15:0] lastRd;
  // released buses show the inverted byte so a stale value never matches
  assign codeData = progStoreN ? ~code[codeAddr[7:0]] :
    code[codeAddr[7:0]];
  assign extReadData = dataReadN ? ~xram[extAddr[7:0]] :
    xram[extAddr[7:0]];
  // writes land on each edge with the strobe low; addresses kept for checks
  always @(posedge clk) begin
    if (!dataWriteN) begin
      xram[extAddr[7:0]] <= extWriteData;
      lastWr <= extAddr;
    end
    if (!dataReadN) begin
      lastRd <= extAddr;
    end
  end
endmodule // mie_mem_model

// *** verif/testbench.sv ***
/*
  testbench: runs short programs through mie_core and checks lengths,
  accumulator and flags. assumes code memory is the partner model.
*/
`timescale 1ns/100ps
module testbench;
  logic clk;
  logic sys_rst;
  wire [15:0] codeAddr;
  wire [7:0] codeData;
  wire progStoreN;
  wire [15:0] extAddr;
  wire [7:0] extWriteData;
  wire [7:0] extReadData;
  wire dataReadN;
  wire dataWriteN;
  wire [7:0] acc;
  wire [7:0] psw;
  wire instrStart;
  int err_total;
  int comparisons;

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
  end
  always #20 clk = ~clk;

  mie_core uut (
    .clk(clk), .sys_rst(sys_rst), .codeAddr(codeAddr),
    .codeData(codeData), .progStoreN(progStoreN), .extAddr(extAddr),
    .extWriteData(extWriteData), .extReadData(extReadData),
    .dataReadN(dataReadN), .dataWriteN(dataWriteN), .acc(acc),
    .psw(psw), .instrStart(instrStart));
  mie_mem_model mem (
    .clk(clk), .codeAddr(codeAddr), .progStoreN(progStoreN),
    .codeData(codeData), .extAddr(extAddr), .extWriteData(extWriteData),
    .extReadData(extReadData), .dataReadN(dataReadN),
    .dataWriteN(dataWriteN));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // sample after the edge so registered outputs have settled
  task automatic tick;
    @(posedge clk);
    #2;
  endtask

  // rest of code space is no-ops; reset and wait for the first fetch
  task automatic boot(input logic [7:0] p [$]);
    int n;
    for (int i = 0; i < 256; i++) mem.code[i] = 8'h00;
    foreach (p[i]) mem.code[i] = p[i];
    @(posedge clk);
    #1 sys_rst = 1'b1;
    repeat (4) @(posedge clk);
    #1 sys_rst = 1'b0;
    n = 0;
    do begin tick; n++; end while (instrStart !== 1'b1 && n < 50);
  endtask

  // one instruction: length in machine cycles and resulting accumulator
  task automatic step(input int mc, input logic [7:0] ea);
    int n;
    n = 0;
    do begin tick; n++; end while (instrStart !== 1'b1 && n < 60);
    chk(16'(n), 16'(mc * 12));
    chk({8'h00, acc}, {8'h00, ea});
  endtask

  task automatic arith_ops;
    boot('{8'h74, 8'hf0, 8'h24, 8'h20, 8'h34, 8'h01, 8'h94, 8'h13,
      8'h94, 8'h00, 8'h04, 8'h14, 8'h78, 8'h03, 8'h28, 8'h75, 8'hf0,
      8'h10, 8'h74, 8'h10, 8'ha4, 8'he5, 8'hf0, 8'h74, 8'h19, 8'h24,
      8'h28, 8'hd4});
    step(1, 8'hf0);
    step(1, 8'h10);
    chk(16'(psw[7]), 16'h0001);
    step(1, 8'h12);
    chk(16'(psw[7]), 16'h0000);
    step(1, 8'hff);
    chk(16'(psw[7]), 16'h0001);
    step(1, 8'hfe);
    step(1, 8'hff);
    step(1, 8'hfe);
    step(1, 8'hfe);
    step(1, 8'h01);
    step(2, 8'h01);
    step(1, 8'h10);
    step(4, 8'h00);
    step(1, 8'h01);
    step(1, 8'h19);
    step(1, 8'h41);
    step(1, 8'h47);
  endtask

  task automatic logic_ops;
    boot('{8'h74, 8'h81, 8'h33, 8'h13, 8'hc4, 8'h44, 8'h0f, 8'h54,
      8'h3c, 8'h64, 8'hff, 8'hf4, 8'h23, 8'h03, 8'h78, 8'h30, 8'hf6,
      8'h74, 8'ha5, 8'hc6, 8'hd6, 8'he6, 8'he4});
    step(1, 8'h81);
    step(1, 8'h02);
    chk(16'(psw[7]), 16'h0001);
    step(1, 8'h81);
    chk(16'(psw[7]), 16'h0000);
    step(1, 8'h18);
    step(1, 8'h1f);
    step(1, 8'h1c);
    step(1, 8'he3);
    step(1, 8'h1c);
    step(1, 8'h38);
    step(1, 8'h1c);
    step(1, 8'h1c);
    step(1, 8'h1c);
    step(1, 8'ha5);
    step(1, 8'h1c);
    step(1, 8'h15);
    step(1, 8'hac);
    step(1, 8'h00);
  endtask

  task automatic direct_ops;
    boot('{8'h75, 8'h30, 8'h5a, 8'h63, 8'h30, 8'hff, 8'h75, 8'h20,
      8'h00, 8'h75, 8'h2f, 8'h00, 8'hd2, 8'h00, 8'hd2, 8'h7f, 8'he5,
      8'h20, 8'he5, 8'h2f, 8'h75, 8'hd0, 8'h08, 8'h78, 8'h77, 8'he5,
      8'h08, 8'ha9, 8'h2f, 8'he5, 8'h09, 8'hc0, 8'h30, 8'he5, 8'h08,
      8'hd0, 8'h40, 8'he5, 8'h40, 8'h85, 8'h2f, 8'h41, 8'he5, 8'h41});
    step(2, 8'h00);
    step(2, 8'h00);
    step(2, 8'h00);
    step(2, 8'h00);
    step(1, 8'h00);
    step(1, 8'h00);
    step(1, 8'h01);
    step(1, 8'h80);
    step(2, 8'h80);
    chk(16'(psw[4:3]), 16'h0001);
    step(1, 8'h80);
    step(1, 8'h77);
    step(2, 8'h77);
    step(1, 8'h80);
    step(2, 8'h80);
    step(1, 8'ha5);
    step(2, 8'ha5);
    step(1, 8'ha5);
    step(2, 8'ha5);
    step(1, 8'h80);
  endtask

  task automatic external_ops;
    mem.xram[5] = 8'h6b;
    boot('{8'h90, 8'h12, 8'hff, 8'ha3, 8'h74, 8'h3c, 8'hf0, 8'he4,
      8'he0, 8'h78, 8'h05, 8'he2, 8'h74, 8'h01, 8'h83, 8'h24, 8'h5d,
      8'h93, 8'h79, 8'h05, 8'he3});
    step(2, 8'h00);
    step(2, 8'h00);
    step(1, 8'h3c);
    step(2, 8'h3c);
    chk(mem.lastWr, 16'h1300);
    chk({8'h00, mem.xram[0]}, 16'h003c);
    step(1, 8'h00);
    step(2, 8'h3c);
    step(1, 8'h3c);
    step(2, 8'h6b);
    chk(mem.lastRd, 16'h0005);
    step(1, 8'h01);
    step(2, 8'h5d);
    step(1, 8'hba);
    step(2, 8'h00);
    step(1, 8'h00);
    step(2, 8'h6b);
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // each scenario reboots, so reset is also exercised in mid-run
  initial begin
    err_total = 0;
    comparisons = 0;
    arith_ops;
    logic_ops;
    direct_ops;
    external_ops;
    close_out;
  end

  // about fourteen times the expected run length
  initial begin
    #600000;
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    close_out;
  end
endmodule // testbench
